// File: ic2_cache.sv
// Two-way set-associative instruction cache with APB control registers.
// Assumes a fetch port that waits on fetchReady and a program memory
// that answers one word per memReq with a one-cycle memAck.
//
// Summary of operation
// [RQ1] 512 sets, two ways, four-word lines
// [RQ2] Line flush clears one line valid flag
// [RQ3] Miss counter adds one per miss
// [RQ4] Freeze bit locks contents against replacement
// [RQ5] Frozen cache still serves hits
// [RQ6] Frozen misses bypass, no array writes
// [RQ7] Clearing freeze restores line fills
// [RQ8] Reset leaves the freeze bit clear
// [RQ9] Freeze covers the whole cache only
// [RQ10] Control bits enable, freeze, flush all
// [RQ11] Unfrozen miss fills whole line, sets valid
// [RQ12] Disabled cache passes fetches straight through
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module ic2_cache
    import ic2_pkg::*;
#(
    parameter int SETS = IC2_SETS
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Instruction fetch port
    input  wire logic                  fetchReq,
    input  wire ic2_addr_t             fetchAddr,
    output logic                       fetchReady,
    output logic                       fetchValid,
    output logic [IC2_DATA_W-1:0]      fetchData,
    // Program memory port
    output logic                       memReq,
    output ic2_addr_t                  memAddr,
    input  wire logic                  memAck,
    input  wire logic [IC2_DATA_W-1:0] memData
);

    if (SETS != IC2_SETS || IC2_WAYS != 2) begin : gChk
        $error("ic2_cache: only 512 sets of two ways are supported");
    end

    if (IC2_LINE_WORDS != (1 << IC2_WORD_W)) begin : gChkLine
        $error("ic2_cache: line words must match the word field width");
    end

    // State
    ic2_state_t              stateFf, nxt_state;
    ic2_addr_t               reqAddrFf;
    logic                    enableFf;
    logic                    cache_freeze_bit_ff;
    logic [31:0]             cache_miss_counter_ff;
    logic                    lineFlushPendFf;
    logic [IC2_IDX_W-1:0]    lineFlushIdxFf;
    logic                    lineFlushWayFf;
    logic [SETS-1:0]         lruFf;
    logic                    victimFf;
    logic [IC2_WORD_W-1:0]   fillCntFf;
    logic [IC2_DATA_W-1:0]   fetchDataFf;
    logic [IC2_DATA_W-1:0]   fillWordFf;
    logic                    fetchValidFf;
    logic [31:0]             prdataFf;

    // Way read results
    ic2_way_rd_t             wayRd [IC2_WAYS];
    logic [IC2_WAYS-1:0]     hitWay;

    // APB decode
    wire logic apbSetup   = psel & ~penable;
    wire logic apbWr      = psel & penable & pwrite;
    wire logic selCtrl    = (paddr == IC2_REG_CTRL);
    wire logic selLflush  = (paddr == IC2_REG_LFLUSH);
    wire logic selMiss    = (paddr == IC2_REG_MISS);
    wire logic selStatus  = (paddr == IC2_REG_STATUS);
    wire logic mapped     = selCtrl | selLflush | selMiss | selStatus;
    wire logic wrCtrl     = apbWr & selCtrl;
    wire logic wrLflush   = apbWr & selLflush;
    wire logic flushAll   = wrCtrl & pwdata[IC2_CTRL_FLUSH_BIT];     // [RQ10]

    // Registers answer in the access phase with no wait states
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdataFf;

    // Read mux; the flush-all bit reads back as zero since it self-clears
    wire logic [31:0] ctrlImage  = {29'h0, 1'b0, cache_freeze_bit_ff, enableFf};
    wire logic [31:0] lflImage   = {22'h0, lineFlushWayFf, lineFlushIdxFf};
    wire logic [31:0] statImage  = {27'h0, lineFlushPendFf, stateFf};
    wire logic [31:0] rdMux      = selCtrl   ? ctrlImage :
                                   selLflush ? lflImage :
                                   selMiss   ? cache_miss_counter_ff :
                                   selStatus ? statImage : 32'h0000_0000;

    // Read data captured in setup so it comes from a flop in access
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdataFf <= 32'h0000_0000;
        end else if (apbSetup) begin
            prdataFf <= rdMux;
        end
    end

    // Control bits; freeze is one bit for the whole cache
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enableFf            <= IC2_EN_RESET;
            cache_freeze_bit_ff <= IC2_FRZ_RESET;                  // [RQ8]
        end else if (wrCtrl) begin
            enableFf            <= pwdata[IC2_CTRL_EN_BIT];        // [RQ10]
            cache_freeze_bit_ff <= pwdata[IC2_CTRL_FRZ_BIT];       // [RQ4] [RQ7] [RQ9]
        end
    end

    // Line flush request; a new write wins over the completion clear
    wire logic lineFlushDo = lineFlushPendFf & (stateFf == IC2_IDLE);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lineFlushPendFf <= 1'b0;
            lineFlushIdxFf  <= '0;
            lineFlushWayFf  <= 1'b0;
        end else if (wrLflush) begin
            lineFlushPendFf <= 1'b1;
            lineFlushIdxFf  <= pwdata[IC2_IDX_W-1:0];
            lineFlushWayFf  <= pwdata[IC2_LFLUSH_WAY_BIT];
        end else if (lineFlushDo) begin
            lineFlushPendFf <= 1'b0;
        end
    end

    // Handshake and lookup terms
    wire logic accept    = fetchReq & fetchReady;
    wire logic frozen    = cache_freeze_bit_ff;
    wire logic isHit     = |hitWay;
    wire logic hitSel    = hitWay[1];
    wire logic missSeen  = (stateFf == IC2_LOOKUP) & ~isHit;
    wire logic pickWay   = ~wayRd[0].valid ? 1'b0 :
                           ~wayRd[1].valid ? 1'b1 : lruFf[reqAddrFf.index];
    wire logic lastWord  = (fillCntFf == IC2_WORD_W'(IC2_LINE_WORDS - 1));
    wire logic fillWrite = (stateFf == IC2_FILL) & memAck;
    wire logic fillDone  = fillWrite & lastWord;

    // Held off while a line flush is pending so it cannot race a fill
    assign fetchReady = (stateFf == IC2_IDLE) & ~lineFlushPendFf;
    assign fetchValid = fetchValidFf;
    assign fetchData  = fetchDataFf;

    // Memory request: single word for bypass, walking words for a fill
    assign memReq  = (stateFf == IC2_BYPASS) | (stateFf == IC2_FILL);
    assign memAddr = (stateFf == IC2_FILL) ?
                     {reqAddrFf.tag, reqAddrFf.index, fillCntFf, 2'b00} :
                     {reqAddrFf.tag, reqAddrFf.index, reqAddrFf.word, 2'b00};

    // Both ways in one loop; only the victim way takes fill writes
    for (genvar w = 0; w < IC2_WAYS; w++) begin : gWay
        wire logic wayFill = fillWrite & (victimFf == 1'(w));      // [RQ6]
        assign hitWay[w] = wayRd[w].valid & (wayRd[w].tag == reqAddrFf.tag)
                           & (stateFf == IC2_LOOKUP);
        ic2_way #(
            .SETS        (SETS)
        ) uWay (
            .clk_sys     (clk_sys),
            .rst         (rst),
            .rdEn        (accept),
            .rdIdx       (fetchAddr.index),
            .rdWord      (fetchAddr.word),
            .rdOut       (wayRd[w]),
            .dataWe      (wayFill),
            .wrIdx       (reqAddrFf.index),
            .wrWord      (fillCntFf),
            .wrData      (memData),
            .lineWe      (wayFill & lastWord),                     // [RQ11]
            .wrTag       (reqAddrFf.tag),
            .validClr    (lineFlushDo & (lineFlushWayFf == 1'(w))), // [RQ2]
            .clrIdx      (lineFlushIdxFf),
            .validClrAll (flushAll)                                // [RQ10]
        );
    end

    // Next state; freeze is sampled in the lookup cycle, so a freeze
    // written mid-fill lets that fill finish
    always_comb begin
        nxt_state = stateFf;
        unique case (stateFf)
            IC2_IDLE: begin
                if (accept) begin
                    nxt_state = enableFf ? IC2_LOOKUP : IC2_BYPASS; // [RQ12]
                end
            end
            IC2_LOOKUP: begin
                if (!isHit) begin
                    nxt_state = frozen ? IC2_BYPASS : IC2_FILL;     // [RQ6] [RQ11]
                end else begin
                    nxt_state = IC2_IDLE;                           // [RQ5]
                end
            end
            IC2_BYPASS: begin
                if (memAck) begin
                    nxt_state = IC2_IDLE;
                end
            end
            IC2_FILL: begin
                if (fillDone) begin
                    nxt_state = IC2_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateFf <= IC2_IDLE;
        end else begin
            stateFf <= nxt_state;
        end
    end

    // Request address, victim choice and fill word counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reqAddrFf <= '0;
            victimFf  <= 1'b0;
            fillCntFf <= '0;
        end else begin
            if (accept) begin
                reqAddrFf <= fetchAddr;
            end
            if (missSeen) begin
                victimFf  <= pickWay;
                fillCntFf <= '0;
            end else if (fillWrite) begin
                fillCntFf <= fillCntFf + IC2_WORD_W'(1);
            end
        end
    end

    // Replacement order: touched way becomes most recent
    // One bit per set is enough for two ways; it names the next victim
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lruFf <= '0;
        end else if (stateFf == IC2_LOOKUP && isHit) begin
            lruFf[reqAddrFf.index] <= ~hitSel;
        end else if (fillDone) begin
            lruFf[reqAddrFf.index] <= ~victimFf;
        end
    end

    // Misses counted only on the cache path; wraps at the top
    // Frozen misses count too; the disabled path never reaches lookup
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cache_miss_counter_ff <= IC2_MISS_RESET;
        end else if (missSeen) begin
            cache_miss_counter_ff <= cache_miss_counter_ff + 32'h0000_0001; // [RQ3]
        end
    end

    // Answer to the fetch unit; the fill returns the asked-for word
    wire logic [IC2_DATA_W-1:0] hitData = hitSel ? wayRd[1].data : wayRd[0].data;
    wire logic wantWord = fillWrite & (fillCntFf == reqAddrFf.word);
    wire logic [IC2_DATA_W-1:0] fillAnswer = wantWord ? memData : fillWordFf;

    // Asked-for word parked until the last word of the line lands, so the
    // answer and the valid pulse leave together
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fillWordFf <= '0;
        end else if (wantWord) begin
            fillWordFf <= memData;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fetchDataFf  <= '0;
            fetchValidFf <= 1'b0;
        end else begin
            fetchValidFf <= 1'b0;
            if (stateFf == IC2_LOOKUP && isHit) begin
                fetchDataFf <= hitData;                           // [RQ5]
            end else if ((stateFf == IC2_BYPASS) && memAck) begin
                fetchDataFf <= memData;                           // [RQ12]
            end else if (fillDone) begin
                fetchDataFf <= fillAnswer;                        // [RQ11]
            end
            if ((stateFf == IC2_LOOKUP && isHit) || fillDone
                || ((stateFf == IC2_BYPASS) && memAck)) begin
                fetchValidFf <= 1'b1;
            end
        end
    end

endmodule : ic2_cache

// File: ic2_pkg.sv
// Shared constants and types for the two-way instruction cache.
// Assumes byte addresses of 24 bits and 32-bit instruction words.
package ic2_pkg;

    // Geometry
    localparam int IC2_SETS       = 512;
    localparam int IC2_WAYS       = 2;
    localparam int IC2_LINE_WORDS = 4;
    localparam int IC2_IDX_W      = 9;
    localparam int IC2_WORD_W     = 2;
    localparam int IC2_TAG_W      = 11;
    localparam int IC2_DATA_W     = 32;

    // APB register byte offsets
    localparam logic [7:0] IC2_REG_CTRL   = 8'h00;
    localparam logic [7:0] IC2_REG_LFLUSH = 8'h04;
    localparam logic [7:0] IC2_REG_MISS   = 8'h08;
    localparam logic [7:0] IC2_REG_STATUS = 8'h0C;

    // Field positions in the control register image (CTRL)
    localparam int IC2_CTRL_EN_BIT    = 0;
    localparam int IC2_CTRL_FRZ_BIT   = 1;
    localparam int IC2_CTRL_FLUSH_BIT = 2;
    localparam logic IC2_EN_RESET     = 1'b0;
    localparam logic IC2_FRZ_RESET    = 1'b0;

    // Line flush register: set index in the low bits, way above it
    localparam int IC2_LFLUSH_WAY_BIT = 9;

    // Miss counter after reset
    localparam logic [31:0] IC2_MISS_RESET = 32'h0000_0000;

    // Byte address split into cache fields
    typedef struct packed {
        logic [IC2_TAG_W-1:0]  tag;
        logic [IC2_IDX_W-1:0]  index;
        logic [IC2_WORD_W-1:0] word;
        logic [1:0]            byteSel;
    } ic2_addr_t;

    // Read view of one way for one set
    typedef struct packed {
        logic                  valid;
        logic [IC2_TAG_W-1:0]  tag;
        logic [IC2_DATA_W-1:0] data;
    } ic2_way_rd_t;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        IC2_IDLE   = 4'b0001,
        IC2_LOOKUP = 4'b0010,
        IC2_BYPASS = 4'b0100,
        IC2_FILL   = 4'b1000
    } ic2_state_t;

endpackage : ic2_pkg

// File: ic2_way.sv
// One way of the cache: tag array, data array and line valid flags.
// Assumes the controller never reads and writes the same word together.
`timescale 1ns/1ns
module ic2_way
    import ic2_pkg::*;
#(
    parameter int SETS = IC2_SETS
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Synchronous read of one word and the set's tag
    input  wire logic                  rdEn,
    input  wire logic [IC2_IDX_W-1:0]  rdIdx,
    input  wire logic [IC2_WORD_W-1:0] rdWord,
    output ic2_way_rd_t                rdOut,
    // Fill writes
    input  wire logic                  dataWe,
    input  wire logic [IC2_IDX_W-1:0]  wrIdx,
    input  wire logic [IC2_WORD_W-1:0] wrWord,
    input  wire logic [IC2_DATA_W-1:0] wrData,
    input  wire logic                  lineWe,
    input  wire logic [IC2_TAG_W-1:0]  wrTag,
    // Invalidation
    input  wire logic                  validClr,
    input  wire logic [IC2_IDX_W-1:0]  clrIdx,
    input  wire logic                  validClrAll
);

    if (SETS != (1 << IC2_IDX_W)) begin : gChk
        $error("ic2_way: SETS must match the index width");
    end

    logic [IC2_DATA_W-1:0] dataMem [SETS*IC2_LINE_WORDS];
    logic [IC2_TAG_W-1:0]  tagMem  [SETS];
    logic [SETS-1:0]       line_valid_flag_ff;
    ic2_way_rd_t           rdOutFf;

    assign rdOut = rdOutFf;

    // Arrays carry no reset; the valid flags alone make contents visible
    always_ff @(posedge clk_sys) begin
        if (dataWe) begin
            dataMem[{wrIdx, wrWord}] <= wrData;
        end
        if (lineWe) begin
            tagMem[wrIdx] <= wrTag;
        end
    end

    // Registered read port
    always_ff @(posedge clk_sys) begin
        if (rdEn) begin
            rdOutFf.data  <= dataMem[{rdIdx, rdWord}];
            rdOutFf.tag   <= tagMem[rdIdx];
            rdOutFf.valid <= line_valid_flag_ff[rdIdx];
        end
    end

    // Valid flags: a fill landing with any clear, even a full flush, wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_valid_flag_ff <= '0;
        end else begin
            if (validClrAll) begin
                line_valid_flag_ff <= '0;                   // [RQ10]
            end else if (validClr) begin
                line_valid_flag_ff[clrIdx] <= 1'b0;         // [RQ2]
            end
            if (lineWe) begin
                line_valid_flag_ff[wrIdx] <= 1'b1;          // [RQ11]
            end
        end
    end

endmodule : ic2_way

// File: ic2_cache_properties.sv
// Port checker for the two-way instruction cache.
// Assumes it is bound to ic2_cache and sees only its ports.
`timescale 1ns/1ns
module ic2_cache_properties
    import ic2_pkg::*;
#(
    parameter int SETS = IC2_SETS
) (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [7:0]            paddr,
    input wire logic                  pslverr,
    // Fetch and memory ports
    input wire logic                  fetchReq,
    input wire logic                  fetchReady,
    input wire logic                  fetchValid,
    input wire logic [IC2_DATA_W-1:0] fetchData,
    input wire logic                  memReq,
    input wire ic2_addr_t             memAddr,
    input wire logic                  memAck
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Access phase and offset decode
    wire apbAcc = psel && penable;
    wire mapped = paddr inside {IC2_REG_CTRL, IC2_REG_LFLUSH, IC2_REG_MISS, IC2_REG_STATUS};

    property p_take_busy; fetchReq && fetchReady |=> !fetchReady; endproperty
    a_take_busy: assert property (p_take_busy) else $error("ready right after take");
    // No memory request after lookup means a hit, answered next cycle
    property p_lookup; fetchReq && fetchReady ##1 !memReq |=> fetchValid ^ memReq; endproperty
    a_lookup: assert property (p_lookup) else $error("lookup gave no answer");
    property p_valid_pulse; fetchValid |=> !fetchValid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("answer longer than one cycle");
    property p_data_hold; !fetchValid |-> $stable(fetchData); endproperty
    a_data_hold: assert property (p_data_hold) else $error("fetch data moved without answer");
    property p_req_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request dropped early");
    property p_byte_zero; memReq |-> memAddr.byteSel == 2'b00; endproperty
    a_byte_zero: assert property (p_byte_zero) else $error("memory address not word aligned");
    // Fill walks the four words of one line in order
    property p_word_step;
        memReq && memAck ##1 memReq |-> memAddr.word == $past(memAddr.word) + 2'd1
            && memAddr.index == $past(memAddr.index);
    endproperty
    a_word_step: assert property (p_word_step) else $error("fill word order broken");
    property p_ack_next; memReq && memAck |=> fetchValid != memReq; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bad step after memory answer");
    property p_err_map; apbAcc && !mapped |-> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
    property p_err_only; pslverr |-> apbAcc && !mapped; endproperty
    a_err_only: assert property (p_err_only) else $error("error on mapped access");
endmodule : ic2_cache_properties

bind ic2_cache ic2_cache_properties #(.SETS(SETS)) uProps (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .pslverr(pslverr), .fetchReq(fetchReq), .fetchReady(fetchReady),
    .fetchValid(fetchValid), .fetchData(fetchData), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck)
);

// File: ic2_mem_model.sv
// Program memory model: one word per request, prompt or slow.
// Assumes the cache holds memReq and memAddr until memAck.
`timescale 1ns/1ns
module ic2_mem_model
    import ic2_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst,
    // Memory port
    input wire logic                  memReq,
    input wire ic2_addr_t             memAddr,
    output logic                      memAck,
    output logic [IC2_DATA_W-1:0]     memData,
    // Bench controls
    input wire logic                  slowMode,
    input wire logic [7:0]            dataGen
);
    logic [1:0] waitCnt_ff;

    // Data toggles between answers so a stale capture shows up
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            memAck     <= 1'b0;
            memData    <= 32'h0;
            waitCnt_ff <= 2'h0;
        end else begin
            memAck  <= 1'b0;
            memData <= ~memData;
            if (memReq && !memAck) begin
                if (waitCnt_ff == (slowMode ? 2'h3 : 2'h0)) begin
                    memAck     <= 1'b1;
                    memData    <= {dataGen, memAddr[23:2], 2'b00};
                    waitCnt_ff <= 2'h0;
                end else begin
                    waitCnt_ff <= waitCnt_ff + 2'h1;
                end
            end
        end
    end
endmodule : ic2_mem_model

// File: ic2_cache_tb.sv
// Self-checking bench for the two-way instruction cache.
// Assumes the memory model answers every word that is requested.
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module ic2_cache_tb
    import ic2_pkg::*;
();
    logic                  clk_sys, rst, psel, penable, pwrite, pready, pslverr, errVal;
    logic [7:0]            paddr, dataGen;
    logic [31:0]           pwdata, prdata, rdVal, rnd;
    logic                  fetchReq, fetchReady, fetchValid, memReq, memAck, slowMode;
    ic2_addr_t             fetchAddr, memAddr;
    logic [IC2_DATA_W-1:0] fetchData, memData;
    logic [1:0]            seen;
    int                    n_fail = 0, tests_run = 0, nAck = 0, seed = 32'hBA66;

    ic2_cache #(.SETS(IC2_SETS)) dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchReady(fetchReady),
        .fetchValid(fetchValid), .fetchData(fetchData), .memReq(memReq),
        .memAddr(memAddr), .memAck(memAck), .memData(memData)
    );
    ic2_mem_model mem (
        .clk_sys(clk_sys), .rst(rst), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .slowMode(slowMode), .dataGen(dataGen)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Counted on the falling edge so reads at the rising edge never race
    always @(negedge clk_sys) if (memAck === 1'b1) nAck++;

    function automatic ic2_addr_t mk(logic [10:0] t, logic [8:0] i, logic [1:0] w);
        return ic2_addr_t'({t, i, w, 2'b11}); // Byte bits set: they must be ignored
    endfunction : mk

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdVal = prdata;
        errVal = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdVal, e)
    endtask : rd

    // One fetch: word answered and number of memory words it cost
    task automatic fetch(input ic2_addr_t a, input int acks, input logic [7:0] g);
        int k;
        int n0;
        k = 0;
        @(posedge clk_sys);
        fetchReq <= 1'b1;
        fetchAddr <= a;
        do begin
            @(posedge clk_sys);
            k++;
        end while (fetchReady !== 1'b1 && k < 50);
        fetchReq <= 1'b0;
        n0 = nAck;
        do begin
            @(posedge clk_sys);
            k++;
        end while (fetchValid !== 1'b1 && k < 200);
        if (k >= 200) begin
            n_fail++;
            tally_and_finish();
        end
        `CHK(fetchData, {g, a[23:2], 2'b00})
        `CHK(nAck - n0, acks)
    endtask : fetch

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, fetchReq, slowMode} = '0;
        fetchAddr = '0;
        dataGen = 8'h01;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, refused and read-only places
        rd(IC2_REG_CTRL, 32'h0);
        rd(IC2_REG_STATUS, 32'h1);
        rd(8'h10, 32'h0);
        `CHK(errVal, 1'b1)
        apb(1'b1, IC2_REG_MISS, 32'h55);
        rd(IC2_REG_MISS, 32'h0);
        // Disabled: straight to memory, nothing counted
        fetch(mk(11'h123, 9'h05A, 2), 1, 8'h01);
        rd(IC2_REG_MISS, 32'h0);
        apb(1'b1, IC2_REG_CTRL, 32'h1);
        fetch(mk(11'h123, 9'h05A, 2), 4, 8'h01);
        rd(IC2_REG_MISS, 32'h1);
        fetch(mk(11'h123, 9'h05A, 1), 0, 8'h01);
        // New memory contents: a hit must still give the old word
        dataGen <= 8'h02;
        apb(1'b1, IC2_REG_CTRL, 32'h3);
        rd(IC2_REG_CTRL, 32'h3);
        fetch(mk(11'h0AA, 9'h05A, 0), 1, 8'h02);
        fetch(mk(11'h0AA, 9'h05A, 0), 1, 8'h02);
        fetch(mk(11'h123, 9'h05A, 3), 0, 8'h01);
        fetch(mk(11'h321, 9'h0F0, 3), 1, 8'h02);
        rd(IC2_REG_MISS, 32'h4);
        apb(1'b1, IC2_REG_CTRL, 32'h1);
        fetch(mk(11'h321, 9'h0F0, 3), 4, 8'h02);
        fetch(mk(11'h321, 9'h0F0, 0), 0, 8'h02);
        // Both ways of one set flushed; the other set is untouched
        apb(1'b1, IC2_REG_LFLUSH, 32'h05A);
        apb(1'b1, IC2_REG_LFLUSH, 32'h25A);
        fetch(mk(11'h123, 9'h05A, 2), 4, 8'h02);
        fetch(mk(11'h321, 9'h0F0, 1), 0, 8'h02);
        apb(1'b1, IC2_REG_CTRL, 32'h5);
        rd(IC2_REG_CTRL, 32'h1);
        fetch(mk(11'h321, 9'h0F0, 1), 4, 8'h02);
        // Random words of two tags sharing a set: both ways keep them
        seen = 2'b00;
        repeat (16) begin
            rnd = $random(seed);
            slowMode <= rnd[0];
            fetch(mk({10'h1F0, rnd[1]}, 9'h1C3, rnd[3:2]), seen[rnd[1]] ? 0 : 4, 8'h02);
            seen[rnd[1]] = 1'b1;
        end
        rd(IC2_REG_MISS, 32'h7 + 32'(seen[0]) + 32'(seen[1]));
        // Reset in mid-run clears freeze and count
        apb(1'b1, IC2_REG_CTRL, 32'h3);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(IC2_REG_CTRL, 32'h0);
        rd(IC2_REG_MISS, 32'h0);
        tally_and_finish();
    end
endmodule : ic2_cache_tb
